// ---- pkg/acc_pkg.sv ----
package acc_pkg;

  // channel select codes
  localparam logic [4:0] CH_PIN_LAST = 5'h0F;
  localparam logic [4:0] CH_GND_FIRST = 5'h10;
  localparam logic [4:0] CH_GND_LAST = 5'h15;
  localparam logic [4:0] CH_TEMP = 5'h1A;
  localparam logic [4:0] CH_BANDGAP = 5'h1B;
  localparam logic [4:0] CH_REFH = 5'h1D;
  localparam logic [4:0] CH_REFL = 5'h1E;
  localparam logic [4:0] CH_OFF = 5'h1F;

  // clock source select
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_LOCAL = 2'h3;

  // power modes
  localparam logic [1:0] PM_RUN = 2'h0;
  localparam logic [1:0] PM_WAIT = 2'h1;
  localparam logic [1:0] PM_STOP3 = 2'h2;
  localparam logic [1:0] PM_STOP2 = 2'h3;

  // conversion length in conversion clock ticks
  localparam int CONV_TICKS = 10;
  localparam int CONV_TICKS8 = 8;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  typedef enum logic [2:0] {
    SRC_PIN,
    SRC_GND,
    SRC_TEMP,
    SRC_BANDGAP,
    SRC_REFH,
    SRC_REFL,
    SRC_RESERVED,
    SRC_NONE
  } acc_src_e;

  typedef struct packed {
    logic [4:0] channel_select;
    logic continuous;
    logic hw_trigger_sel;
    logic [1:0] clk_source;
    logic [1:0] clock_divide_select;
    logic mode8;
    logic compare_en;
    logic compare_ge;
  } acc_cfg_s;

endpackage

// ---- verilog/acc_ctl.sv ----
`timescale 1ns/1ns
// Behaviour
// - codes 0..15 route pins 0..15; codes 16..21 convert ground
// - reserved codes still convert; result undefined
// - 26 temp sensor, 27 bandgap, 29 high ref, 30 low ref
// - four input clocks: bus, bus/2, local async, alternate
// - alternate clock input is the external reference clock
// - conversion clock is selected clock divided by divide field
// - alternate clock stays usable in wait mode
// - alternate clock unavailable in stop2 and stop3
// - hardware trigger from counter overflow starts a conversion
// - overflow triggers regardless of counter interrupt enable
// - hardware trigger works in run, wait and stop3
// - result right-justified as 10 or 8 bits
// - single or continuous; single returns by itself to idle, or to armed under hardware trigger
// - done flag set on result, with interrupt request
// - compare less-than or greater-or-equal; flag and irq on match
// - only 16 pins; no third pin-enable register
// - all-ones select shuts down, stops continuous, no extra conversion
// - done flag clears on control write or low result read
module acc_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration and control
  input wire acc_pkg::acc_cfg_s cfg,
  input wire logic ctrl_write,
  input wire logic result_low_read,
  input wire logic conv_irq_enable,
  input wire logic [9:0] compare_value,
  input wire logic [1:0] power_mode,
  // clock sources, taken as enables on clk
  input wire logic local_async_conv_clock,
  input wire logic ext_reference_clock,
  // trigger from the real-time counter
  input wire logic rtc_overflow,
  input wire logic rtc_irq_enable,
  // analog front end
  input wire logic analog_bit,
  output logic [4:0] analog_mux_sel,
  output acc_pkg::acc_src_e analog_src,
  output logic [15:0] pin_select,
  output logic analog_powered,
  // status
  output logic conversion_clock,
  output logic busy,
  output logic conv_done_flag,
  output logic conv_irq,
  output logic [9:0] result
);

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} acc_state_e;

  acc_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [9:0] sar_q;
  logic [2:0] div_cnt_q;
  logic half_q;
  logic tick;
  logic src_tick;
  logic alt_ok;
  logic start;
  logic done;
  logic match;
  logic [9:0] final_val;
  logic [2:0] div_last;
  logic [3:0] eff_ticks;

  // ----------------------------------------
  // channel decode
  // ----------------------------------------
  assign analog_mux_sel = cfg.channel_select;
  assign analog_powered = cfg.channel_select != acc_pkg::CH_OFF;
  always_comb begin
    pin_select = 16'h0000;
    if (cfg.channel_select <= acc_pkg::CH_PIN_LAST) begin
      analog_src = acc_pkg::SRC_PIN;
      pin_select[cfg.channel_select[3:0]] = 1'b1;
    end else if (cfg.channel_select <= acc_pkg::CH_GND_LAST) begin
      analog_src = acc_pkg::SRC_GND;
    end else if (cfg.channel_select == acc_pkg::CH_TEMP) begin
      analog_src = acc_pkg::SRC_TEMP;
    end else if (cfg.channel_select == acc_pkg::CH_BANDGAP) begin
      analog_src = acc_pkg::SRC_BANDGAP;
    end else if (cfg.channel_select == acc_pkg::CH_REFH) begin
      analog_src = acc_pkg::SRC_REFH;
    end else if (cfg.channel_select == acc_pkg::CH_REFL) begin
      analog_src = acc_pkg::SRC_REFL;
    end else if (cfg.channel_select == acc_pkg::CH_OFF) begin
      analog_src = acc_pkg::SRC_NONE;
    end else begin
      analog_src = acc_pkg::SRC_RESERVED;
    end
  end
  // sixteen pins only, so no enables exist above pin 15

  // ----------------------------------------
  // conversion clock
  // ----------------------------------------
  // alternate clock ok in run and wait
  assign alt_ok = (power_mode == acc_pkg::PM_RUN) || (power_mode == acc_pkg::PM_WAIT);
  // source select; alternate is external reference
  always_comb begin
    case (cfg.clk_source)
      acc_pkg::CLK_BUS: src_tick = 1'b1;
      acc_pkg::CLK_BUS_DIV2: src_tick = half_q;
      acc_pkg::CLK_ALT: src_tick = ext_reference_clock && alt_ok;
      default: src_tick = local_async_conv_clock;
    endcase
  end
  // divide by 1, 2, 4 or 8
  assign div_last = 3'((4'h1 << cfg.clock_divide_select) - 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 3'h0;
    end else if (src_tick) begin
      div_cnt_q <= (div_cnt_q >= div_last) ? 3'h0 : div_cnt_q + 3'h1;
    end
  end
  assign tick = src_tick && (div_cnt_q >= div_last);
  assign conversion_clock = tick;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // software write or hardware trigger
  // overflow alone starts; counter irq enable ignored
  // no power mode gating on the trigger
  assign start = cfg.hw_trigger_sel ? rtc_overflow : ctrl_write;
  assign eff_ticks = cfg.mode8 ? 4'(acc_pkg::CONV_TICKS8) : 4'(acc_pkg::CONV_TICKS);
  assign done = (state_q == ST_CONV) && tick && (bit_cnt_q == eff_ticks - 4'h1);
  assign busy = state_q == ST_CONV;
  assign final_val = {sar_q[8:0], analog_bit};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      sar_q <= 10'h000;
    end else if (!analog_powered) begin
      // shut down with no extra conversion
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
    end else if (ctrl_write && !cfg.hw_trigger_sel) begin
      // control write aborts and restarts
      state_q <= ST_CONV;
      bit_cnt_q <= 4'h0;
      sar_q <= 10'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ctrl_write) begin
            state_q <= ST_ARMED;
          end else if (start) begin
            state_q <= ST_CONV;
            bit_cnt_q <= 4'h0;
          end
        end
        ST_ARMED: begin
          if (start) begin
            state_q <= ST_CONV;
            bit_cnt_q <= 4'h0;
          end
        end
        ST_CONV: begin
          if (tick) begin
            sar_q <= final_val;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (done) begin
              bit_cnt_q <= 4'h0;
              // single returns to idle, or to armed under hardware trigger; continuous restarts
              state_q <= cfg.continuous ? ST_CONV : (cfg.hw_trigger_sel ? ST_ARMED : ST_IDLE);
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // result, compare and flag
  // ----------------------------------------
  // less-than or greater-or-equal
  assign match = !cfg.compare_en ||
                 (cfg.compare_ge ? (final_val >= compare_value) : (final_val < compare_value));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= acc_pkg::RESULT_RESET;
    end else if (done && match) begin
      result <= cfg.mode8 ? {2'h0, final_val[7:0]} : final_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_done_flag <= 1'b0;
    end else if (done && match) begin
      conv_done_flag <= 1'b1;
    end else if (ctrl_write || result_low_read) begin
      conv_done_flag <= 1'b0;
    end
  end
  assign conv_irq = conv_done_flag && conv_irq_enable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // flag follows completion
  a_done_sets_flag: assert property (@(posedge clk) disable iff (rst)
    done && match |=> conv_done_flag)
    else $error("done flag not set");
  a_flag_clears: assert property (@(posedge clk) disable iff (rst)
    (ctrl_write || result_low_read) && !(done && match) |=> !conv_done_flag)
    else $error("done flag not cleared");
  a_flag_hold: assert property (@(posedge clk) disable iff (rst)
    conv_done_flag && !ctrl_write && !result_low_read |=> conv_done_flag)
    else $error("done flag dropped without clear");
  a_off_idle: assert property (@(posedge clk) disable iff (rst)
    !analog_powered |=> !busy)
    else $error("busy while disabled");
  a_off_select: assert property (@(posedge clk) disable iff (rst)
    !analog_powered |-> analog_src == acc_pkg::SRC_NONE && pin_select == 16'h0000)
    else $error("input not isolated while disabled");
  a_alt_stop: assert property (@(posedge clk) disable iff (rst)
    cfg.clk_source == acc_pkg::CLK_ALT && !alt_ok |-> !tick)
    else $error("alternate clock used in stop");
  a_alt_wait: assert property (@(posedge clk) disable iff (rst)
    cfg.clk_source == acc_pkg::CLK_ALT && power_mode == acc_pkg::PM_WAIT && ext_reference_clock &&
    cfg.clock_divide_select == 2'h0 |-> tick)
    else $error("alternate clock lost in wait");
  a_bus_tick: assert property (@(posedge clk) disable iff (rst)
    cfg.clk_source == acc_pkg::CLK_BUS && cfg.clock_divide_select == 2'h0 |-> tick)
    else $error("bus clock tick missing");
  a_div_spacing: assert property (@(posedge clk) disable iff (rst)
    tick && cfg.clock_divide_select != 2'h0 ##1 cfg.clock_divide_select != 2'h0 |-> !tick)
    else $error("divided clock ticked twice in a row");
  a_fmt_eight: assert property (@(posedge clk) disable iff (rst)
    done && match && cfg.mode8 |=> result[9:8] == 2'h0)
    else $error("eight-bit result not justified");
  a_single_idle: assert property (@(posedge clk) disable iff (rst)
    done && !cfg.continuous && !ctrl_write && analog_powered |=> !busy)
    else $error("single conversion did not stop");
  a_cont_restart: assert property (@(posedge clk) disable iff (rst)
    done && cfg.continuous && analog_powered && !ctrl_write |=> busy)
    else $error("continuous conversion stopped");
  a_sw_start: assert property (@(posedge clk) disable iff (rst)
    ctrl_write && !cfg.hw_trigger_sel && analog_powered |=> busy)
    else $error("control write did not start conversion");
  a_hw_start: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ARMED && rtc_overflow && analog_powered && !ctrl_write |=> busy)
    else $error("overflow did not start conversion");
  a_hw_no_gate: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ARMED && cfg.hw_trigger_sel && rtc_overflow && !rtc_irq_enable && analog_powered &&
    !ctrl_write |=> busy)
    else $error("overflow ignored without counter irq enable");
  a_trig_stop3: assert property (@(posedge clk) disable iff (rst)
    power_mode == acc_pkg::PM_STOP3 && state_q == ST_ARMED && cfg.hw_trigger_sel && rtc_overflow &&
    analog_powered && !ctrl_write |=> busy)
    else $error("overflow ignored in stop3");
  a_miss_no_flag: assert property (@(posedge clk) disable iff (rst)
    !conv_done_flag && done && !match && !ctrl_write && !result_low_read |=> !conv_done_flag)
    else $error("flag set on compare miss");
  a_result_kept: assert property (@(posedge clk) disable iff (rst)
    done && !match |=> $stable(result))
    else $error("result changed on compare miss");
  a_pin_route: assert property (@(posedge clk) disable iff (rst)
    cfg.channel_select <= acc_pkg::CH_PIN_LAST |-> $onehot(pin_select))
    else $error("pin select not one-hot");
  a_gnd_route: assert property (@(posedge clk) disable iff (rst)
    cfg.channel_select >= acc_pkg::CH_GND_FIRST && cfg.channel_select <= acc_pkg::CH_GND_LAST |->
    analog_src == acc_pkg::SRC_GND && pin_select == 16'h0000)
    else $error("ground code misrouted");
  a_reserved_conv: assert property (@(posedge clk) disable iff (rst)
    analog_src == acc_pkg::SRC_RESERVED && ctrl_write && !cfg.hw_trigger_sel |=> busy)
    else $error("reserved code did not convert");
  a_src_temp: assert property (@(posedge clk) disable iff (rst)
    cfg.channel_select == acc_pkg::CH_TEMP |-> analog_src == acc_pkg::SRC_TEMP)
    else $error("temperature code misrouted");
  a_src_bandgap: assert property (@(posedge clk) disable iff (rst)
    cfg.channel_select == acc_pkg::CH_BANDGAP |-> analog_src == acc_pkg::SRC_BANDGAP)
    else $error("bandgap code misrouted");
  a_irq_flag: assert property (@(posedge clk) disable iff (rst)
    conv_irq |-> conv_done_flag)
    else $error("irq without flag");
  a_irq_follow: assert property (@(posedge clk) disable iff (rst)
    conv_done_flag && conv_irq_enable |-> conv_irq)
    else $error("flag without irq");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_single: cover property (@(posedge clk) disable iff (rst) done && !cfg.continuous);
  c_continuous: cover property (@(posedge clk) disable iff (rst) done && cfg.continuous ##1 busy);
  c_hw: cover property (@(posedge clk) disable iff (rst) state_q == ST_ARMED && rtc_overflow);
  c_compare: cover property (@(posedge clk) disable iff (rst) done && cfg.compare_en && match);
  c_shutdown: cover property (@(posedge clk) disable iff (rst) busy ##1 !analog_powered);

endmodule

// ---- tb/acc_analog_model.sv ----
`timescale 1ns/1ns
// ----------
// analog sources seen by the converter
// ----------
module acc_analog_model (
  // converter side
  input wire logic clk,
  input wire logic rst,
  input wire logic busy,
  input wire logic conversion_clock,
  input wire acc_pkg::acc_src_e analog_src,
  input wire logic [4:0] analog_mux_sel,
  input wire logic mode8,
  // comparator decision
  output logic analog_bit
);
  logic [9:0] level;
  logic [3:0] idx_q;
  logic flip_q;
  always_comb begin
    case (analog_src)
      acc_pkg::SRC_PIN: level = {analog_mux_sel, 5'h0B};
      acc_pkg::SRC_TEMP: level = 10'h1C7;
      acc_pkg::SRC_BANDGAP: level = 10'h2A5;
      acc_pkg::SRC_REFH: level = 10'h3FF;
      acc_pkg::SRC_RESERVED, acc_pkg::SRC_NONE: level = {5{flip_q, ~flip_q}};
      default: level = 10'h000;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q <= 4'h0;
      flip_q <= 1'b0;
    end else begin
      flip_q <= ~flip_q;
      if (!busy) idx_q <= 4'h0;
      else if (conversion_clock) idx_q <= (idx_q == (mode8 ? 4'h7 : 4'h9)) ? 4'h0 : idx_q + 4'h1;
    end
  end
  // msb first, one bit per tick
  assign analog_bit = level[4'h9 - idx_q];
endmodule

// ---- tb/adc_channel_clock_trigger_ctl_tb_top.sv ----
`timescale 1ns/1ns
module adc_channel_clock_trigger_ctl_tb_top;
  logic clk = 1'b0, rst = 1'b1, ctrl_write = 1'b0, result_low_read = 1'b0, irq_en = 1'b0;
  logic local_tick = 1'b0, ext_tick = 1'b0, rtc_overflow = 1'b0, rtc_irq_enable = 1'b0, analog_bit;
  logic [9:0] compare_value = 10'h000, result, e;
  logic [1:0] power_mode = 2'h0;
  logic [4:0] mux_sel;
  logic [15:0] pin_select;
  logic powered, conv_clk, busy, flag, irq;
  acc_pkg::acc_cfg_s cfg = '0;
  acc_pkg::acc_src_e src;
  int fail_count = 0, n_checks = 0, cyc, ticks = 0, seed = 32'hEE149A91;
  logic [31:0] r;
  acc_ctl DUT (.clk(clk), .rst(rst), .cfg(cfg), .ctrl_write(ctrl_write), .result_low_read(result_low_read),
    .conv_irq_enable(irq_en), .compare_value(compare_value), .power_mode(power_mode),
    .local_async_conv_clock(local_tick),
    .ext_reference_clock(ext_tick), .rtc_overflow(rtc_overflow), .rtc_irq_enable(rtc_irq_enable),
    .analog_bit(analog_bit), .analog_mux_sel(mux_sel), .analog_src(src), .pin_select(pin_select),
    .analog_powered(powered), .conversion_clock(conv_clk), .busy(busy), .conv_done_flag(flag),
    .conv_irq(irq), .result(result));
  acc_analog_model u_src (.clk(clk), .rst(rst), .busy(busy), .conversion_clock(conv_clk), .analog_src(src),
    .analog_mux_sel(mux_sel), .mode8(cfg.mode8), .analog_bit(analog_bit));
  always #50 clk = ~clk;
  // random tick enables; a hung run is cut short
  always @(posedge clk) begin
    #10;
    r = $random(seed);
    local_tick = r[0];
    ext_tick = r[1];
    ticks++;
    if (ticks > 40000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conv(input logic [4:0] ch, input int lim);
    cfg.channel_select = ch;
    ctrl_write = 1'b1;
    step(1);
    ctrl_write = 1'b0;
    cyc = 1;
    while (flag !== 1'b1 && cyc < lim) begin
      step(1);
      cyc++;
    end
  endtask
  task automatic rd();
    result_low_read = 1'b1;
    step(1);
    result_low_read = 1'b0;
  endtask
  function automatic logic [9:0] lvl(input logic [4:0] c);
    if (c <= acc_pkg::CH_PIN_LAST) return {c, 5'h0B};
    if (c == acc_pkg::CH_TEMP) return 10'h1C7;
    if (c == acc_pkg::CH_BANDGAP) return 10'h2A5;
    if (c == acc_pkg::CH_REFH) return 10'h3FF;
    return 10'h000;
  endfunction
  function automatic acc_pkg::acc_src_e esrc(input logic [4:0] c);
    if (c <= acc_pkg::CH_PIN_LAST) return acc_pkg::SRC_PIN;
    if (c <= acc_pkg::CH_GND_LAST) return acc_pkg::SRC_GND;
    if (c == acc_pkg::CH_TEMP) return acc_pkg::SRC_TEMP;
    if (c == acc_pkg::CH_BANDGAP) return acc_pkg::SRC_BANDGAP;
    if (c == acc_pkg::CH_REFH) return acc_pkg::SRC_REFH;
    if (c == acc_pkg::CH_REFL) return acc_pkg::SRC_REFL;
    if (c == acc_pkg::CH_OFF) return acc_pkg::SRC_NONE;
    return acc_pkg::SRC_RESERVED;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    step(12);
    rst = 1'b0;
    chk("reset", 16'h0000, {busy, flag, 4'h0, result});
    // every code, bus clock undivided
    for (int c = 0; c < 32; c++) begin
      cfg.mode8 = c[0];
      conv(c[4:0], 40);
      chk("source", 16'(esrc(c[4:0])), 16'(src));
      chk("mux", 16'(c[4:0]), 16'(mux_sel));
      chk("pins", (c < 16) ? 16'(16'h0001 << c) : 16'h0000, pin_select);
      chk("done", {15'h0, c != 31}, {15'h0, flag});
      chk("powered", {15'h0, c != 31}, {15'h0, powered});
      e = lvl(c[4:0]);
      if (esrc(c[4:0]) != acc_pkg::SRC_RESERVED && c != 31)
        chk("result", c[0] ? {8'h00, e[9:2]} : {6'h00, e}, {6'h00, result});
      if (c == 0) chk("latency", 16'h000B, 16'(cyc));
      chk("idle", 16'h0000, {15'h0, busy});
      rd();
      chk("flag clear", 16'h0000, {15'h0, flag});
    end
    cfg.mode8 = 1'b0;
    // every source and divide
    for (int s = 0; s < 4; s++) for (int d = 0; d < 4; d++) begin
      cfg.clk_source = s[1:0];
      cfg.clock_divide_select = d[1:0];
      conv(5'h03, 400);
      chk("src div done", 16'h0001, {15'h0, flag});
      // first tick lands 1 to 2**d cycles after the start, then nine more full periods
      if (s == 0) chk("div time", 16'h0001, {15'h0, cyc >= (9 << d) + 2 && cyc <= (10 << d) + 1});
      rd();
    end
    // alternate clock across power modes
    cfg.clock_divide_select = 2'h0;
    cfg.clk_source = acc_pkg::CLK_ALT;
    for (int p = 0; p < 4; p++) begin
      power_mode = p[1:0];
      conv(5'h07, 80);
      chk("alt mode", {15'h0, p < 2}, {15'h0, flag});
      conv(acc_pkg::CH_OFF, 2);
    end
    power_mode = acc_pkg::PM_RUN;
    cfg.clk_source = acc_pkg::CLK_BUS;
    // compare at the boundary, both senses
    cfg.compare_en = 1'b1;
    irq_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      cfg.compare_ge = k[0];
      compare_value = lvl({1'b0, r[3:0]}) + 10'(k[1]);
      conv({1'b0, r[3:0]}, 40);
      chk("compare", {15'h0, k[0] ^ k[1]}, {15'h0, flag});
      chk("irq", {15'h0, k[0] ^ k[1]}, {15'h0, irq});
      rd();
    end
    cfg.compare_en = 1'b0;
    // hardware trigger in run, wait, stop3
    cfg.hw_trigger_sel = 1'b1;
    for (int p = 0; p < 3; p++) begin
      power_mode = p[1:0];
      rtc_irq_enable = p[0];
      conv(5'h09, 20);
      chk("armed only", 16'h0000, {15'h0, flag});
      rtc_overflow = 1'b1;
      step(1);
      rtc_overflow = 1'b0;
      step(15);
      chk("hw start", 16'h0001, {15'h0, flag});
      rd();
    end
    // continuous runs on until shut down
    power_mode = acc_pkg::PM_RUN;
    cfg.hw_trigger_sel = 1'b0;
    cfg.continuous = 1'b1;
    conv(5'h05, 40);
    rd();
    step(14);
    chk("again", 16'h0001, {15'h0, flag});
    conv(acc_pkg::CH_OFF, 1);
    chk("off clears", 16'h0000, {15'h0, flag});
    step(30);
    chk("no extra", 16'h0000, {14'h0, flag, busy});
    stop_test();
  end
endmodule
